//--- hdl/mrie_exec.sv
// Executor for move, load-literal, no-operation and return instructions
// Operation
// - Move W to 7-bit file address, one cycle
// - Load 8-bit literal into W, one cycle
// - Literal don't-care bits ignored by decoder
// - Interrupt return pops stack into PC, two cycles
// - Interrupt return sets global interrupt enable bit
// - Literal return loads W and popped PC
// - Subroutine return pops stack into PC
`timescale 1ns/1ps
`include "mrie_defines.svh"

module mrie_exec
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic instr_valid_in,
    input wire logic [13:0] instr_in,
    input wire logic [12:0] top_of_stack_in,
    output logic [7:0] w_out,
    output logic file_we_out,
    output logic [6:0] file_addr_out,
    output logic [7:0] file_data_out,
    output logic stack_pop_out,
    output logic pc_load_out,
    output logic [12:0] pc_out,
    output logic global_interrupt_enable_out,
    output logic flush_out,
    output logic unhandled_out
);
    import mrie_pkg::*;

    function automatic mrie_instr_e decode(input logic [13:0] op);
        if ((op & `MRIE_MOVE_MASK) == `MRIE_MOVE_PAT)
            decode = MRIE_I_MOVE_W;
        else if ((op & `MRIE_LOADL_MASK) == `MRIE_LOADL_PAT)
            decode = MRIE_I_LOADL;
        else if ((op & `MRIE_RETL_MASK) == `MRIE_RETL_PAT)
            decode = MRIE_I_RETL;
        else if (op == `MRIE_RETURN_OP)
            decode = MRIE_I_RETURN;
        else if (op == `MRIE_RETINT_OP)
            decode = MRIE_I_RETINT;
        else if (op == `MRIE_NO_OP_OP)
            decode = MRIE_I_NO_OP;
        else
            decode = MRIE_I_OTHER;
    endfunction

    mrie_state_e state_r, state_nxt;
    logic [7:0] w_r, w_nxt;
    logic we_r, we_nxt;
    logic [6:0] faddr_r, faddr_nxt;
    logic [7:0] fdata_r, fdata_nxt;
    logic pop_r, pop_nxt;
    logic pcld_r, pcld_nxt;
    logic [12:0] pc_r, pc_nxt;
    logic ien_r, ien_nxt;
    logic flush_r, flush_nxt;
    logic unh_r, unh_nxt;
    mrie_instr_e kind;

    always_comb
    begin
        kind = decode(instr_in);
        state_nxt = MRIE_S_EXEC;
        w_nxt = w_r;
        we_nxt = 1'b0;
        faddr_nxt = faddr_r;
        fdata_nxt = fdata_r;
        pop_nxt = 1'b0;
        pcld_nxt = 1'b0;
        pc_nxt = pc_r;
        ien_nxt = ien_r;
        flush_nxt = 1'b0;
        unh_nxt = 1'b0;
        case (state_r)
            MRIE_S_FLUSH:
            begin
                flush_nxt = 1'b1;
                state_nxt = MRIE_S_EXEC;
            end
            MRIE_S_EXEC:
            begin
                if (instr_valid_in)
                begin
                    case (kind)
                        MRIE_I_MOVE_W:
                        begin
                            we_nxt = 1'b1;
                            faddr_nxt = instr_in[`MRIE_FILE_ADDR_W-1:0];
                            fdata_nxt = w_r;
                        end
                        MRIE_I_LOADL:
                        begin
                            w_nxt = instr_in[`MRIE_LIT_W-1:0];
                        end
                        MRIE_I_RETL:
                        begin
                            w_nxt = instr_in[`MRIE_LIT_W-1:0];
                            pop_nxt = 1'b1;
                            pcld_nxt = 1'b1;
                            pc_nxt = top_of_stack_in;
                            state_nxt = MRIE_S_FLUSH;
                        end
                        MRIE_I_RETURN:
                        begin
                            pop_nxt = 1'b1;
                            pcld_nxt = 1'b1;
                            pc_nxt = top_of_stack_in;
                            state_nxt = MRIE_S_FLUSH;
                        end
                        MRIE_I_RETINT:
                        begin
                            pop_nxt = 1'b1;
                            pcld_nxt = 1'b1;
                            pc_nxt = top_of_stack_in;
                            ien_nxt = 1'b1;
                            state_nxt = MRIE_S_FLUSH;
                        end
                        MRIE_I_NO_OP:
                        begin
                            unh_nxt = 1'b0;
                        end
                        default:
                        begin
                            unh_nxt = 1'b1;
                        end
                    endcase
                end
            end
            default:
            begin
                state_nxt = MRIE_S_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            state_r <= MRIE_S_EXEC;
            w_r <= `MRIE_W_RST;
            we_r <= 1'b0;
            faddr_r <= `MRIE_FADDR_RST;
            fdata_r <= `MRIE_FDATA_RST;
            pop_r <= 1'b0;
            pcld_r <= 1'b0;
            pc_r <= `MRIE_PC_RST;
            ien_r <= `MRIE_IEN_RST;
            flush_r <= 1'b0;
            unh_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            w_r <= w_nxt;
            we_r <= we_nxt;
            faddr_r <= faddr_nxt;
            fdata_r <= fdata_nxt;
            pop_r <= pop_nxt;
            pcld_r <= pcld_nxt;
            pc_r <= pc_nxt;
            ien_r <= ien_nxt;
            flush_r <= flush_nxt;
            unh_r <= unh_nxt;
        end
    end

    assign w_out = w_r;
    assign file_we_out = we_r;
    assign file_addr_out = faddr_r;
    assign file_data_out = fdata_r;
    assign stack_pop_out = pop_r;
    assign pc_load_out = pcld_r;
    assign pc_out = pc_r;
    assign global_interrupt_enable_out = ien_r;
    assign flush_out = flush_r;
    assign unhandled_out = unh_r;

    property p_move_w;
        @(posedge clk_sys_in) disable iff (rst_in)
        (state_r == MRIE_S_EXEC && instr_valid_in && kind == MRIE_I_MOVE_W)
        |=> (file_we_out && file_addr_out == $past(instr_in[`MRIE_FILE_ADDR_W-1:0])
            && file_data_out == $past(w_r));
    endproperty
    a_move_w: assert property (p_move_w) else $error("file write wrong");

    property p_loadl;
        @(posedge clk_sys_in) disable iff (rst_in)
        (state_r == MRIE_S_EXEC && instr_valid_in
            && (instr_in & `MRIE_LOADL_MASK) == `MRIE_LOADL_PAT)
        |=> (w_out == $past(instr_in[`MRIE_LIT_W-1:0]) && !pc_load_out);
    endproperty
    a_loadl: assert property (p_loadl) else $error("literal load wrong");

    // Literal with don't-care bits set must still land in W
    property p_dontcare;
        @(posedge clk_sys_in) disable iff (rst_in)
        (state_r == MRIE_S_EXEC && instr_valid_in
            && (instr_in & `MRIE_LOADL_MASK) == `MRIE_LOADL_PAT
            && |(instr_in & `MRIE_LOADL_DC_MASK))
        |=> (w_out == $past(instr_in[`MRIE_LIT_W-1:0]) && !unhandled_out);
    endproperty
    a_dontcare: assert property (p_dontcare) else $error("literal not decoded");

    property p_retint;
        @(posedge clk_sys_in) disable iff (rst_in)
        (state_r == MRIE_S_EXEC && instr_valid_in && instr_in == `MRIE_RETINT_OP)
        |=> (stack_pop_out && pc_load_out && pc_out == $past(top_of_stack_in)) ##1 flush_out;
    endproperty
    a_retint: assert property (p_retint) else $error("interrupt return wrong");

    property p_int_enable;
        @(posedge clk_sys_in) disable iff (rst_in)
        (state_r == MRIE_S_EXEC && instr_valid_in && instr_in == `MRIE_RETINT_OP)
        |=> global_interrupt_enable_out;
    endproperty
    a_int_enable: assert property (p_int_enable) else $error("enable not set");

    property p_retl;
        @(posedge clk_sys_in) disable iff (rst_in)
        (state_r == MRIE_S_EXEC && instr_valid_in
            && (instr_in & `MRIE_RETL_MASK) == `MRIE_RETL_PAT)
        |=> (w_out == $past(instr_in[`MRIE_LIT_W-1:0]) && pc_out == $past(top_of_stack_in)
            && stack_pop_out && pc_load_out);
    endproperty
    a_retl: assert property (p_retl) else $error("literal return wrong");

    property p_return;
        @(posedge clk_sys_in) disable iff (rst_in)
        (state_r == MRIE_S_EXEC && instr_valid_in && instr_in == `MRIE_RETURN_OP)
        |=> (stack_pop_out && pc_load_out && pc_out == $past(top_of_stack_in)
            && $stable(global_interrupt_enable_out));
    endproperty
    a_return: assert property (p_return) else $error("subroutine return wrong");

    property p_flush;
        @(posedge clk_sys_in) disable iff (rst_in)
        pc_load_out |=> (flush_out && !file_we_out && !stack_pop_out && $stable(w_out));
    endproperty
    a_flush: assert property (p_flush) else $error("fetched word not flushed");

    c_move_w: cover property (@(posedge clk_sys_in) disable iff (rst_in) file_we_out);
    c_retint: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(global_interrupt_enable_out));
    c_retl: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        pc_load_out ##1 flush_out);
endmodule // mrie_exec

//--- hdl/mrie_defines.svh
// Opcode patterns, field positions and widths for the move and return executor
`ifndef MRIE_DEFINES_SVH
`define MRIE_DEFINES_SVH
`define MRIE_OP_W 14
`define MRIE_PC_W 13
`define MRIE_FILE_ADDR_W 7
`define MRIE_LIT_W 8
// Move W to file: 00 0000 1fff ffff
`define MRIE_MOVE_MASK 14'h3F80
`define MRIE_MOVE_PAT 14'h0080
// Load literal: 11 00xx kkkk kkkk (don't-care bits 9:8)
`define MRIE_LOADL_MASK 14'h3C00
`define MRIE_LOADL_PAT 14'h3000
`define MRIE_LOADL_DC_MASK 14'h0300
// Return with literal: 11 01xx kkkk kkkk
`define MRIE_RETL_MASK 14'h3C00
`define MRIE_RETL_PAT 14'h3400
`define MRIE_RETURN_OP 14'h0008
`define MRIE_RETINT_OP 14'h0009
`define MRIE_NO_OP_OP 14'h0000
`define MRIE_IEN_BIT 7
`define MRIE_W_RST 8'h00
`define MRIE_IEN_RST 1'h0
`define MRIE_PC_RST 13'h0000
`define MRIE_FADDR_RST 7'h00
`define MRIE_FDATA_RST 8'h00
`endif

//--- hdl/mrie_pkg.sv
// Types shared by the move and return executor
package mrie_pkg;
    typedef enum logic [2:0] {
        MRIE_I_NO_OP = 3'h0,
        MRIE_I_MOVE_W = 3'h1,
        MRIE_I_LOADL = 3'h2,
        MRIE_I_RETURN = 3'h3,
        MRIE_I_RETINT = 3'h4,
        MRIE_I_RETL = 3'h5,
        MRIE_I_OTHER = 3'h6
    } mrie_instr_e;
    typedef enum logic [0:0] {
        MRIE_S_EXEC = 1'h0,
        MRIE_S_FLUSH = 1'h1
    } mrie_state_e;
endpackage

//--- verification/test_mrie_exec.sv
// Self-checking bench for the move and return executor
`timescale 1ns/1ps
`include "mrie_defines.svh"

module test_mrie_exec;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic instr_valid_in = 1'b0;
    logic [13:0] instr_in = 14'h0000;
    logic [12:0] top_of_stack_in = 13'h0000;
    logic [7:0] w_out;
    logic file_we_out;
    logic [6:0] file_addr_out;
    logic [7:0] file_data_out;
    logic stack_pop_out;
    logic pc_load_out;
    logic [12:0] pc_out;
    logic global_interrupt_enable_out;
    logic flush_out;
    logic unhandled_out;
    logic [31:0] seed = 32'h1E1F;
    int n_errors = 0;
    int compares = 0;
    logic [7:0] exp_w = 8'h00;
    logic exp_ien = 1'b0;
    logic [12:0] exp_pc = 13'h0000;
    logic [6:0] exp_addr = 7'h00;
    logic [7:0] exp_data = 8'h00;
    logic [13:0] corner [8] = '{14'h00FF, 14'h0080, 14'h33FF, 14'h0100, 14'h0008,
                                 14'h0009, 14'h37A5, 14'h0000};

    mrie_exec DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .top_of_stack_in(top_of_stack_in), .w_out(w_out),
        .file_we_out(file_we_out), .file_addr_out(file_addr_out),
        .file_data_out(file_data_out), .stack_pop_out(stack_pop_out),
        .pc_load_out(pc_load_out), .pc_out(pc_out),
        .global_interrupt_enable_out(global_interrupt_enable_out),
        .flush_out(flush_out), .unhandled_out(unhandled_out));

    initial
    begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check_outs(input logic we, input logic pop, input logic fl, input logic unh);
        chk("w_out", 16'(w_out), 16'(exp_w));
        chk("file_we_out", 16'(file_we_out), 16'(we));
        chk("file_addr_out", 16'(file_addr_out), 16'(exp_addr));
        chk("file_data_out", 16'(file_data_out), 16'(exp_data));
        chk("stack_pop_out", 16'(stack_pop_out), 16'(pop));
        chk("pc_load_out", 16'(pc_load_out), 16'(pop));
        chk("pc_out", 16'(pc_out), 16'(exp_pc));
        chk("global_interrupt_enable_out", 16'(global_interrupt_enable_out), 16'(exp_ien));
        chk("flush_out", 16'(flush_out), 16'(fl));
        chk("unhandled_out", 16'(unhandled_out), 16'(unh));
    endtask

    // Present one word, predict its effect, and feed junk into the flush slot of a return
    task automatic issue(input logic [13:0] op, input logic [12:0] stack_top);
        logic we;
        logic pop;
        logic unh;
        we = 1'b0;
        pop = 1'b0;
        unh = 1'b0;
        instr_valid_in = 1'b1;
        instr_in = op;
        top_of_stack_in = stack_top;
        if ((op & `MRIE_MOVE_MASK) == `MRIE_MOVE_PAT)
        begin
            we = 1'b1;
            exp_addr = op[6:0];
            exp_data = exp_w;
        end
        else if ((op & `MRIE_LOADL_MASK) == `MRIE_LOADL_PAT)
            exp_w = op[7:0];
        else if ((op & `MRIE_RETL_MASK) == `MRIE_RETL_PAT)
        begin
            pop = 1'b1;
            exp_w = op[7:0];
        end
        else if (op == `MRIE_RETURN_OP)
            pop = 1'b1;
        else if (op == `MRIE_RETINT_OP)
        begin
            pop = 1'b1;
            exp_ien = 1'b1;
        end
        else if (op != `MRIE_NO_OP_OP)
            unh = 1'b1;
        if (pop)
            exp_pc = stack_top;
        @(negedge clk_sys_in);
        check_outs(we, pop, 1'b0, unh);
        if (pop)
        begin
            seed = xs(seed);
            instr_in = 14'h3000 | 14'(seed[7:0]);
            top_of_stack_in = seed[28:16];
            @(negedge clk_sys_in);
            check_outs(1'b0, 1'b0, 1'b1, 1'b0);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(negedge clk_sys_in);
        check_outs(1'b0, 1'b0, 1'b0, 1'b0);
        rst_in = 1'b0;
        foreach (corner[i])
            issue(corner[i], 13'h1FFF - 13'(i));
        repeat (300)
        begin
            seed = xs(seed);
            case (seed[2:0] % 3'h6)
                3'h0: issue(14'h0080 | 14'(seed[14:8]), seed[28:16]);
                3'h1: issue(14'h3000 | 14'(seed[17:8]), seed[28:16]);
                3'h2: issue(14'h0000, seed[28:16]);
                3'h3: issue(14'h0008, seed[28:16]);
                3'h4: issue(14'h0009, seed[28:16]);
                default: issue(14'h3400 | 14'(seed[17:8]), seed[28:16]);
            endcase
        end
        // Mid-run reset clears the enable, then an interrupt return sets it again
        rst_in = 1'b1;
        instr_valid_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        exp_w = `MRIE_W_RST;
        exp_ien = `MRIE_IEN_RST;
        exp_pc = `MRIE_PC_RST;
        exp_addr = `MRIE_FADDR_RST;
        exp_data = `MRIE_FDATA_RST;
        check_outs(1'b0, 1'b0, 1'b0, 1'b0);
        rst_in = 1'b0;
        issue(`MRIE_RETINT_OP, 13'h0ABC);
        // Idle cycle: a word without valid must leave everything alone
        instr_valid_in = 1'b0;
        instr_in = 14'h00AA;
        @(negedge clk_sys_in);
        check_outs(1'b0, 1'b0, 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule // test_mrie_exec
